// ### hw/tmz_pkg.sv
// Shared constants and types of the timer zero block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package tmz_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;

    localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH_BUFFER = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_CONTROL = 4'hc;

    localparam int BIT_IRQ_ENABLE = 5;
    localparam int BIT_OVERFLOW_FLAG = 2;

    localparam logic [BYTE_W-1:0] TIMER_CONTROL_RESET = 8'hff;
    localparam logic [BYTE_W-1:0] HIGH_BUFFER_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    localparam int CLKS_PER_INSTR = 4;
    localparam int INHIBIT_INSTR_CYCLES = 2;
    localparam int RATIO_W = 3;

    typedef struct packed {
        logic timer_run;
        logic width_select;
        logic clock_source_select;
        logic edge_select;
        logic prescaler_bypass;
        logic [RATIO_W-1:0] prescale_ratio;
    } tmz_control_type;

    typedef enum {
        BUS_IDLE,
        BUS_ANSWER
    } tmz_bus_state_type;

endpackage : tmz_pkg

// ### hw/tmz_edge_sync.sv
// Synchroniser and edge detector for the external counter input.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ns
module tmz_edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic sync_first;
    logic sync_second;
    logic sync_last;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            sync_last <= 1'b0;
        end else begin
            sync_first <= pin;
            sync_second <= sync_first;
            sync_last <= sync_second;
        end
    end

    assign rise = sync_second & ~sync_last;
    assign fall = ~sync_second & sync_last;

endmodule : tmz_edge_sync

// ### hw/tmz_prescaler.sv
// Eight-bit prescaler that passes every 2^(ratio+1)-th input pulse.
// Assumes input pulses last one clock and clear wins over counting.
`timescale 1ns/1ns
module tmz_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic pulse_in,
    input wire logic [tmz_pkg::RATIO_W-1:0] ratio,
    output logic pulse_out
);
    import tmz_pkg::*;

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    function automatic logic [WIDTH-1:0] ratio_mask(input logic [RATIO_W-1:0] r);
        logic [WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (i <= int'(r)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : ratio_mask

    assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

    // Counter is internal only; software never reads or writes it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (pulse_in) begin
            count <= next_count;
        end
    end

    assign pulse_out = pulse_in & ~clear &
        ((count & ratio_mask(ratio)) == ratio_mask(ratio));

endmodule : tmz_prescaler

// ### hw/tmz_timer.sv
// Timer zero: 8/16-bit timer or counter with prescaler and overflow flag.
// Assumes an Avalon-MM master on REF_CLK and a counter input sampled on REF_CLK.
//
// Contract
// - Counting happens only while timer_run is set; clearing it holds the count.
// - width_select set gives 8-bit counting, cleared gives 16-bit counting.
// - clock_source_select set counts pin edges, cleared counts instruction cycles.
// - edge_select set counts falling pin edges, cleared counts rising edges.
// - prescaler_bypass set skips the prescaler; cleared clocks from its output.
// - prescale_ratio n divides by two to the power n plus one.
// - Timer mode without prescaler advances once per instruction cycle.
// - A count write blocks incrementing for the next two instruction cycles.
// - The pin is synchronised first and its increment lands on a later cycle.
// - The prescaler is an eight-bit counter hidden from software.
// - A count write clears the prescaler when assigned, keeping the assignment.
// - Prescaler assignment may change at any time while running.
// - Rollover from all ones to zero sets overflow_flag.
// - overflow_irq_enable gates the request; the flag still records overflows.
// - overflow_flag stays set until software clears it.
// - Overflow cannot wake from sleep; counting stops while sleeping.
// - Reading the low byte in 16-bit mode snapshots the upper byte into the buffer.
// - The high-byte register touches only the buffer, never the counter.
// - Writing the low byte in 16-bit mode loads the upper byte from the buffer together.
// - Reset sets control to all ones and the high buffer to zero.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module tmz_timer #(
    parameter int CLKS_PER_INSTR = tmz_pkg::CLKS_PER_INSTR,
    parameter int PRESCALE_WIDTH = 8
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [tmz_pkg::ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [tmz_pkg::DATA_W-1:0] WRITEDATA,
    output logic [tmz_pkg::DATA_W-1:0] READDATA,
    output logic WAITREQUEST,
    input wire logic COUNTER_INPUT_PIN,
    input wire logic LOW_POWER_SLEEP,
    output logic OVERFLOW_IRQ
);
    import tmz_pkg::*;

    localparam int PHASE_W = $clog2(CLKS_PER_INSTR);
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CLKS_PER_INSTR - 1);
    localparam logic [1:0] INHIBIT_LOAD = 2'(INHIBIT_INSTR_CYCLES);

    tmz_control_type timer_control;
    tmz_bus_state_type bus_state;
    logic [BYTE_W-1:0] count_low_byte;
    logic [BYTE_W-1:0] count_upper;
    logic [BYTE_W-1:0] count_high_buffer;
    logic overflow_flag;
    logic overflow_irq_enable;

    logic [PHASE_W-1:0] phase;
    logic instr_tick;
    logic [1:0] inhibit;
    logic pin_rise;
    logic pin_fall;
    logic pin_pending;
    logic source_event;
    logic prescaled_event;
    logic count_event;
    logic increment;
    logic rollover;
    logic [BYTE_W-1:0] next_low;
    logic [BYTE_W-1:0] next_upper;

    logic launch;
    logic accept;
    logic accept_write;
    logic write_low;
    logic write_high;
    logic write_control;
    logic write_intr;
    logic read_low_launch;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : addr_is

    // Bus handshake: request seen in IDLE, answered one cycle later.
    assign launch = (bus_state == BUS_IDLE) && (READ || WRITE);
    assign accept = (bus_state == BUS_ANSWER) && !WAITREQUEST;
    assign accept_write = accept && WRITE;
    assign write_low = accept_write && addr_is(ADDRESS, OFF_COUNT_LOW);
    assign write_high = accept_write && addr_is(ADDRESS, OFF_COUNT_HIGH_BUFFER);
    assign write_control = accept_write && addr_is(ADDRESS, OFF_TIMER_CONTROL);
    assign write_intr = accept_write && addr_is(ADDRESS, OFF_INTERRUPT_CONTROL);
    assign read_low_launch = launch && READ && addr_is(ADDRESS, OFF_COUNT_LOW);

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bus_state <= BUS_IDLE;
            WAITREQUEST <= 1'b1;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (launch) begin
                        bus_state <= BUS_ANSWER;
                        WAITREQUEST <= 1'b0;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                    WAITREQUEST <= 1'b1;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    WAITREQUEST <= 1'b1;
                end
            endcase
        end
    end

    // Read data are captured at launch and stand through the accepting edge.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            READDATA <= READ_ZERO;
        end else if (launch) begin
            READDATA <= READ_ZERO;
            if (READ) begin
                case (ADDRESS)
                    OFF_TIMER_CONTROL: begin
                        READDATA[BYTE_W-1:0] <= timer_control;
                    end
                    OFF_COUNT_LOW: begin
                        READDATA[BYTE_W-1:0] <= count_low_byte;
                    end
                    OFF_COUNT_HIGH_BUFFER: begin
                        READDATA[BYTE_W-1:0] <= count_high_buffer;
                    end
                    OFF_INTERRUPT_CONTROL: begin
                        READDATA[BIT_IRQ_ENABLE] <= overflow_irq_enable;
                        READDATA[BIT_OVERFLOW_FLAG] <= overflow_flag;
                    end
                    default: begin
                        READDATA <= READ_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            timer_control <= TIMER_CONTROL_RESET;
        end else if (write_control) begin
            timer_control <= WRITEDATA[BYTE_W-1:0];
        end
    end

    // High buffer: software writes it, a low-byte read in 16-bit mode refreshes it.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            count_high_buffer <= HIGH_BUFFER_RESET;
        end else if (write_high) begin
            count_high_buffer <= WRITEDATA[BYTE_W-1:0];
        end else if (read_low_launch && !timer_control.width_select) begin
            count_high_buffer <= count_upper;
        end
    end

    // Instruction cycle tick derived from the reference clock.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            phase <= '0;
        end else if (phase == PHASE_LAST) begin
            phase <= '0;
        end else begin
            phase <= phase + PHASE_W'(1);
        end
    end

    assign instr_tick = (phase == PHASE_LAST);

    tmz_edge_sync u_edge_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .pin(COUNTER_INPUT_PIN),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // A synchronised pin edge waits for the next instruction tick; a new edge wins.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_pending <= 1'b0;
        end else if (timer_control.edge_select ? pin_fall : pin_rise) begin
            pin_pending <= 1'b1;
        end else if (instr_tick) begin
            pin_pending <= 1'b0;
        end
    end

    assign source_event = timer_control.clock_source_select ?
        (instr_tick && pin_pending) : instr_tick;

    tmz_prescaler #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescaler (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .clear(write_low && !timer_control.prescaler_bypass),
        .pulse_in(source_event),
        .ratio(timer_control.prescale_ratio),
        .pulse_out(prescaled_event)
    );

    assign count_event = timer_control.prescaler_bypass ?
        source_event : prescaled_event;

    // Two instruction cycles of inhibit after every write of the count.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            inhibit <= 2'h0;
        end else if (write_low) begin
            inhibit <= INHIBIT_LOAD;
        end else if (instr_tick && inhibit != 2'h0) begin
            inhibit <= inhibit - 2'h1;
        end
    end

    assign increment = timer_control.timer_run && (inhibit == 2'h0) &&
        !LOW_POWER_SLEEP && count_event;

    assign rollover = timer_control.width_select ?
        (count_low_byte == BYTE_ALL_ONES) :
        ({count_upper, count_low_byte} == {BYTE_ALL_ONES, BYTE_ALL_ONES});

    assign next_low = count_low_byte + BYTE_W'(1);
    assign next_upper = (count_low_byte == BYTE_ALL_ONES) ?
        count_upper + BYTE_W'(1) : count_upper;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            count_low_byte <= COUNT_RESET;
        end else if (write_low) begin
            count_low_byte <= WRITEDATA[BYTE_W-1:0];
        end else if (increment) begin
            count_low_byte <= next_low;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            count_upper <= COUNT_RESET;
        end else if (write_low && !timer_control.width_select) begin
            count_upper <= count_high_buffer;
        end else if (increment && !timer_control.width_select) begin
            count_upper <= next_upper;
        end
    end

    // Overflow sets the flag; a set in the same cycle as a software clear wins.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            overflow_flag <= 1'b0;
        end else if (increment && rollover) begin
            overflow_flag <= 1'b1;
        end else if (write_intr) begin
            overflow_flag <= WRITEDATA[BIT_OVERFLOW_FLAG];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            overflow_irq_enable <= 1'b0;
        end else if (write_intr) begin
            overflow_irq_enable <= WRITEDATA[BIT_IRQ_ENABLE];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            OVERFLOW_IRQ <= 1'b0;
        end else begin
            OVERFLOW_IRQ <= overflow_flag && overflow_irq_enable;
        end
    end

endmodule : tmz_timer

// ### sim/tmz_pulse_src.sv
// Model of the pulse source that drives the counter input pin.
// Assumes it runs from the bench clock; the pin rests low between bursts.
`timescale 1ns/1ns
module tmz_pulse_src (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;
    task automatic set_level(input logic v, input int hold);
        @(posedge clk);
        pin <= v;
        repeat (hold) @(posedge clk);
    endtask : set_level
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            set_level(1'b1, w);
            set_level(1'b0, w);
        end
    endtask : pulses
endmodule : tmz_pulse_src

// ### sim/tmz_monitor.sv
// Checker of the timer zero block that watches only its top-level ports.
// Assumes one wait cycle per access and the request output one cycle behind the flag.
`timescale 1ns/1ns
module tmz_monitor (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [tmz_pkg::ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [tmz_pkg::DATA_W-1:0] WRITEDATA,
    input wire logic [tmz_pkg::DATA_W-1:0] READDATA,
    input wire logic WAITREQUEST,
    input wire logic LOW_POWER_SLEEP,
    input wire logic OVERFLOW_IRQ
);
    import tmz_pkg::*;
    logic wr_ic;
    assign wr_ic = WRITE && !WAITREQUEST && ADDRESS == OFF_INTERRUPT_CONTROL;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_answer;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    a_read_answer: assert property ($rose(READ) |=> s_answer)
        else $error("read not answered after one wait cycle");
    a_write_answer: assert property ($rose(WRITE) |=> s_answer)
        else $error("write not answered after one wait cycle");
    a_idle_wait: assert property (!READ && !WRITE |=> WAITREQUEST)
        else $error("wait request dropped without a request");
    a_data_stands: assert property (!$fell(WAITREQUEST) |-> $stable(READDATA))
        else $error("read data changed outside an answer");
    a_unmapped_zero: assert property (READ && !WAITREQUEST && ADDRESS[1:0] != 2'h0
        |-> READDATA == READ_ZERO)
        else $error("unmapped read returned nonzero data");
    a_reset_outputs: assert property ($rose(RST_N) |-> WAITREQUEST && !OVERFLOW_IRQ)
        else $error("outputs not at reset values");
    a_irq_masked: assert property (wr_ic && !WRITEDATA[BIT_IRQ_ENABLE] |-> ##2 !OVERFLOW_IRQ)
        else $error("request not masked by cleared enable");
    a_irq_holds: assert property (OVERFLOW_IRQ && !wr_ic && !$past(wr_ic) |=> OVERFLOW_IRQ)
        else $error("request dropped without software clear");
    a_sleep_no_wake: assert property ($rose(OVERFLOW_IRQ) |->
        !$past(LOW_POWER_SLEEP, 2) || $past(wr_ic, 2))
        else $error("overflow raised while asleep");
endmodule : tmz_monitor
bind tmz_timer tmz_monitor u_mon (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .LOW_POWER_SLEEP(LOW_POWER_SLEEP), .OVERFLOW_IRQ(OVERFLOW_IRQ));

// ### sim/tb_top.sv
// Self-checking bench of the timer zero block over its register bus and counter pin.
// Assumes the package, design files, pulse-source model and checker are compiled first.
`timescale 1ns/1ns
module tb_top;
    import tmz_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = 32'h0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic pin;
    logic sleep = 1'b0;
    logic irq;
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] q2;
    int num_errors = 0;
    int n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    tmz_timer dut (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDRESS(address), .READ(read),
        .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
        .COUNTER_INPUT_PIN(pin), .LOW_POWER_SLEEP(sleep), .OVERFLOW_IRQ(irq));
    tmz_pulse_src src (.clk(ref_clk), .pin(pin));
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
        n_checks++;
        if (seen !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", w, e, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            num_errors++;
            give_verdict();
        end
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rc(input string w, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        check(w, q, {24'h0, e});
    endtask : rc
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle
    task automatic span(input int c, input logic [7:0] e);
        bus(1'b0, OFF_COUNT_LOW, 32'h0);
        q2 = q;
        idle(c - 3);
        bus(1'b0, OFF_COUNT_LOW, 32'h0);
        check("count step", {24'h0, q[7:0] - q2[7:0]}, {24'h0, e});
    endtask : span
    task automatic t_reset;
        rc("timer_control", OFF_TIMER_CONTROL, 8'hff);
        rc("count_high_buffer", OFF_COUNT_HIGH_BUFFER, 8'h00);
        rc("interrupt_control", OFF_INTERRUPT_CONTROL, 8'h00);
        wr(4'h1, 8'h12);
        rc("unmapped", 4'h1, 8'h00);
        rc("timer_control kept", OFF_TIMER_CONTROL, 8'hff);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rate;
        wr(OFF_TIMER_CONTROL, 8'h48);
        wr(OFF_COUNT_LOW, 8'h10);
        idle(40);
        rc("held count", OFF_COUNT_LOW, 8'h10);
        wr(OFF_TIMER_CONTROL, 8'hc8);
        span(40, 8'h0a);
        for (int k = 0; k < 8; k++) begin
            wr(OFF_TIMER_CONTROL, {5'b11000, 3'(k)});
            span(16 << (k + 1), 8'h04);
        end
        wr(OFF_TIMER_CONTROL, 8'hc8);
        wr(OFF_COUNT_LOW, 8'h00);
        idle(36);
        bus(1'b0, OFF_COUNT_LOW, 32'h0);
        check("inhibit", 32'(q == 32'h8 || q == 32'h7), 32'h1);
        $display("test rate done");
    endtask : t_rate
    task automatic t_clear;
        wr(OFF_TIMER_CONTROL, 8'hc7);
        wr(OFF_COUNT_LOW, 8'h00);
        idle(800);
        wr(OFF_COUNT_LOW, 8'h00);
        idle(400);
        rc("cleared prescaler", OFF_COUNT_LOW, 8'h00);
        rc("assignment kept", OFF_TIMER_CONTROL, 8'hc7);
        wr(OFF_TIMER_CONTROL, 8'hcf);
        span(40, 8'h0a);
        $display("test clear done");
    endtask : t_clear
    task automatic t_ovf;
        wr(OFF_TIMER_CONTROL, 8'h48);
        wr(OFF_COUNT_HIGH_BUFFER, 8'h55);
        wr(OFF_COUNT_LOW, 8'hfe);
        wr(OFF_INTERRUPT_CONTROL, 8'h20);
        wr(OFF_TIMER_CONTROL, 8'hc8);
        idle(40);
        check("irq", 32'(irq), 32'h1);
        rc("flag kept", OFF_INTERRUPT_CONTROL, 8'h24);
        wr(OFF_TIMER_CONTROL, 8'h08);
        bus(1'b0, OFF_COUNT_LOW, 32'h0);
        rc("upper untouched", OFF_COUNT_HIGH_BUFFER, 8'h00);
        wr(OFF_INTERRUPT_CONTROL, 8'h04);
        idle(3);
        check("masked irq", 32'(irq), 32'h0);
        rc("flag recorded", OFF_INTERRUPT_CONTROL, 8'h04);
        wr(OFF_INTERRUPT_CONTROL, 8'h00);
        rc("flag cleared", OFF_INTERRUPT_CONTROL, 8'h00);
        wr(OFF_COUNT_HIGH_BUFFER, 8'hff);
        wr(OFF_COUNT_LOW, 8'hfc);
        wr(OFF_COUNT_HIGH_BUFFER, 8'h00);
        rc("low loaded", OFF_COUNT_LOW, 8'hfc);
        rc("upper snapshot", OFF_COUNT_HIGH_BUFFER, 8'hff);
        wr(OFF_TIMER_CONTROL, 8'h88);
        idle(40);
        bus(1'b0, OFF_COUNT_LOW, 32'h0);
        rc("wrapped upper", OFF_COUNT_HIGH_BUFFER, 8'h00);
        rc("flag 16-bit", OFF_INTERRUPT_CONTROL, 8'h04);
        $display("test overflow done");
    endtask : t_ovf
    task automatic t_pin;
        wr(OFF_TIMER_CONTROL, 8'he8);
        wr(OFF_COUNT_LOW, 8'h00);
        idle(12);
        src.set_level(1'b1, 20);
        rc("rising counted", OFF_COUNT_LOW, 8'h01);
        src.set_level(1'b0, 20);
        rc("falling ignored", OFF_COUNT_LOW, 8'h01);
        wr(OFF_TIMER_CONTROL, 8'hf8);
        src.set_level(1'b1, 20);
        rc("rising ignored", OFF_COUNT_LOW, 8'h01);
        src.set_level(1'b0, 20);
        rc("falling counted", OFF_COUNT_LOW, 8'h02);
        src.pulses(6, 2);
        idle(12);
        rc("pin count", OFF_COUNT_LOW, 8'h08);
        wr(OFF_TIMER_CONTROL, 8'he1);
        wr(OFF_COUNT_LOW, 8'h00);
        idle(12);
        src.pulses(8, 4);
        idle(12);
        rc("prescaled pin", OFF_COUNT_LOW, 8'h02);
        $display("test pin done");
    endtask : t_pin
    task automatic t_sleep;
        wr(OFF_TIMER_CONTROL, 8'hc8);
        wr(OFF_INTERRUPT_CONTROL, 8'h20);
        wr(OFF_COUNT_LOW, 8'hfe);
        sleep <= 1'b1;
        idle(60);
        check("sleep irq", 32'(irq), 32'h0);
        rc("frozen", OFF_COUNT_LOW, 8'hfe);
        sleep <= 1'b0;
        idle(40);
        check("wake irq", 32'(irq), 32'h1);
        $display("test sleep done");
    endtask : t_sleep
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_rate();
        t_clear();
        t_ovf();
        t_pin();
        t_sleep();
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end
endmodule : tb_top
